// ===== design/delay_timer.sv
// Loadable down-counter that times every controller state.
// Assumes the loader gives the state length minus one.
`timescale 1ns/1ps
module delay_timer #(
	parameter int WIDTH = 14
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Load request and value
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	// Count reached zero
	output logic done
);
	// Remaining cycles
	logic [WIDTH-1:0] count;

	if (WIDTH < 2) begin : g_width_check
		$error("delay_timer needs WIDTH of at least 2");
	end

	// Load wins over counting; stops at zero
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
		end else if (load) begin
			count <= load_value;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	// Zero means the current state has run its length
	assign done = (count == '0);
endmodule

// ===== design/dram_host_ctrl.sv
// Host controller driving the strobes, address and data pins of the memory module.
// Assumes pins reach the module directly; read data arrives asynchronously.
`timescale 1ns/1ps
module dram_host_ctrl #(
	parameter int ADDR_HALF = 9,
	parameter int DATA_BITS = 8,
	parameter int INIT_WAIT_CYC = dram_host_pkg::INIT_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Request side
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [2*ADDR_HALF-1:0] req_addr,
	input wire logic [DATA_BITS-1:0] req_wdata,
	// Read answer side
	output logic rsp_valid,
	output logic [DATA_BITS-1:0] rsp_rdata,
	output logic init_done,
	// Memory pins
	output logic row_strobe_b,
	output logic col_strobe_b,
	output logic write_strobe_b,
	output logic [ADDR_HALF-1:0] mux_address_lines,
	input wire logic [DATA_BITS-1:0] byte_data_lines_in,
	output logic [DATA_BITS-1:0] byte_data_lines_out,
	output logic byte_data_lines_oe
);
	localparam int TB = dram_host_pkg::TIMER_BITS;
	localparam int AB = dram_host_pkg::AGE_BITS;
	localparam int T_RC = dram_host_pkg::TRC_CYC;
	localparam int REF_AGE_LIMIT = 1200;

	if (ADDR_HALF < 8 || DATA_BITS < 1 || INIT_WAIT_CYC < 1 ||
		INIT_WAIT_CYC >= (1 << TB) || dram_host_pkg::RCD_CYC < 2) begin : g_param_check
		$error("dram_host_ctrl parameters out of range");
	end

	dram_host_pkg::state_type state, next_state;
	logic timer_load; // Entering a new state, or loading the power-up pause
	logic [TB-1:0] timer_value; // Its length minus one
	logic timer_done;
	logic [AB-1:0] ras_age; // Cycles since row strobe fell
	logic [3:0] wake_count; // Wake-up cycles issued
	logic pause_armed; // Power-up pause timer loaded
	logic [TB-1:0] ref_timer; // Cycles to next refresh slot
	logic refresh_due; // A refresh slot is owed
	logic [AB-1:0] refresh_age; // Cycles a refresh has waited
	logic [ADDR_HALF-1:0] row, col; // Captured address halves
	logic is_write; // Current access direction
	logic [DATA_BITS-1:0] wdata;
	logic [DATA_BITS-1:0] dq_meta, dq_sync; // Pin synchroniser
	logic same_row, page_ok, accept;

	// State timer
	delay_timer #(.WIDTH(TB)) u_timer (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.load(timer_load),
		.load_value(timer_value),
		.done(timer_done)
	);

	// Page reuse only for the open row and only while time remains
	assign same_row = (req_addr[2*ADDR_HALF-1:ADDR_HALF] == row);
	assign page_ok = same_row && !refresh_due &&
		(32'(ras_age) + dram_host_pkg::PAGE_SLOT_CYC < dram_host_pkg::RAS_MAX_CYC);
	// Requests taken in idle or in a page gap
	assign req_ready = (state == dram_host_pkg::st_idle && timer_done && !refresh_due) ||
		(state == dram_host_pkg::st_gap && timer_done && page_ok);
	assign accept = req_valid && req_ready;

	// Next state and the length of the state entered
	always_comb begin
		next_state = state;
		timer_load = 1'b0;
		timer_value = '0;
		case (state)
			dram_host_pkg::st_init: begin
				if (!pause_armed) begin
					timer_load = 1'b1; // Power-up pause, loaded once
					timer_value = TB'(INIT_WAIT_CYC - 1);
				end else if (timer_done) begin
					next_state = dram_host_pkg::st_wake_ras;
				end
			end
			dram_host_pkg::st_wake_ras, dram_host_pkg::st_cbr_ras,
			dram_host_pkg::st_hid_ras, dram_host_pkg::st_close: begin
				// Row strobe stays low its least width
				if (timer_done && 32'(ras_age) + 1 >= dram_host_pkg::RAS_MIN_CYC) begin
					next_state = dram_host_pkg::st_pre;
				end
			end
			dram_host_pkg::st_pre: begin
				// Precharge and fall-to-fall spacing both met
				// Wake cycles fall straight from here, so the full spacing is kept here
				if (timer_done && 32'(ras_age) + 1 >= T_RC) begin
					if (wake_count < 4'(dram_host_pkg::WAKE_CYCLES)) begin
						next_state = dram_host_pkg::st_wake_ras;
					end else begin
						next_state = dram_host_pkg::st_idle;
					end
				end
			end
			dram_host_pkg::st_idle: begin
				if (refresh_due) begin
					next_state = dram_host_pkg::st_cbr_cas;
				end else if (accept) begin
					next_state = dram_host_pkg::st_act;
				end
			end
			dram_host_pkg::st_act: begin
				if (timer_done) begin
					next_state = dram_host_pkg::st_setup;
				end
			end
			dram_host_pkg::st_setup: begin
				next_state = dram_host_pkg::st_col;
			end
			dram_host_pkg::st_col: begin
				if (timer_done) begin
					// Hidden refresh only behind a read
					if (refresh_due && !is_write) begin
						next_state = dram_host_pkg::st_hid_pre;
					end else begin
						next_state = dram_host_pkg::st_gap;
					end
				end
			end
			dram_host_pkg::st_gap: begin
				if (timer_done) begin
					if (accept) begin
						next_state = dram_host_pkg::st_setup;
					end else begin
						next_state = dram_host_pkg::st_close;
					end
				end
			end
			dram_host_pkg::st_cbr_cas: begin
				if (timer_done) begin
					next_state = dram_host_pkg::st_cbr_ras;
				end
			end
			dram_host_pkg::st_hid_pre: begin
				if (timer_done) begin
					next_state = dram_host_pkg::st_hid_ras;
				end
			end
			default: begin
				next_state = dram_host_pkg::st_init;
			end
		endcase
		if (next_state != state) begin
			timer_load = 1'b1;
			case (next_state)
				dram_host_pkg::st_wake_ras, dram_host_pkg::st_cbr_ras, dram_host_pkg::st_hid_ras:
					timer_value = TB'(dram_host_pkg::RAS_MIN_CYC - 1);
				dram_host_pkg::st_pre, dram_host_pkg::st_hid_pre:
					timer_value = TB'(dram_host_pkg::RP_CYC - 1);
				dram_host_pkg::st_act: timer_value = TB'(dram_host_pkg::RCD_CYC - 2);
				dram_host_pkg::st_col: timer_value = is_write ?
					TB'(dram_host_pkg::COL_WRITE_CYC - 1) : TB'(dram_host_pkg::COL_READ_CYC - 1);
				dram_host_pkg::st_gap: timer_value = TB'(dram_host_pkg::CP_CYC - 1);
				dram_host_pkg::st_cbr_cas: timer_value = TB'(dram_host_pkg::CSR_CYC - 1);
				default: timer_value = '0;
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= dram_host_pkg::st_init;
		end else begin
			state <= next_state;
		end
	end

	// Power-up pause armed on the first edge out of reset; the timer itself resets to zero
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pause_armed <= 1'b0;
		end else begin
			pause_armed <= 1'b1;
		end
	end

	// Age since the row strobe last fell; saturates
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ras_age <= '1;
		end else if (row_strobe_b && next_state inside {dram_host_pkg::st_wake_ras,
			dram_host_pkg::st_act, dram_host_pkg::st_cbr_ras, dram_host_pkg::st_hid_ras}) begin
			ras_age <= '0;
		end else if (ras_age != '1) begin
			ras_age <= ras_age + 1'b1;
		end
	end

	// Wake-up counter and ready flag
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_count <= '0;
			init_done <= 1'b0;
		end else begin
			if (state != dram_host_pkg::st_wake_ras && next_state == dram_host_pkg::st_wake_ras) begin
				wake_count <= wake_count + 1'b1;
			end
			if (next_state == dram_host_pkg::st_idle) begin
				init_done <= 1'b1;
			end
		end
	end

	// Evenly spaced refresh slots; a new slot wins over a clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_timer <= TB'(dram_host_pkg::REF_SPACING_CYC - 1);
			refresh_due <= 1'b0;
			refresh_age <= '0;
		end else begin
			if (ref_timer == '0) begin
				ref_timer <= TB'(dram_host_pkg::REF_SPACING_CYC - 1);
			end else begin
				ref_timer <= ref_timer - 1'b1;
			end
			if (ref_timer == '0 && init_done) begin
				refresh_due <= 1'b1;
			end else if (next_state inside {dram_host_pkg::st_cbr_ras, dram_host_pkg::st_hid_ras}) begin
				refresh_due <= 1'b0;
			end
			refresh_age <= refresh_due ? refresh_age + 1'b1 : '0;
		end
	end

	// Capture of an accepted request
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			row <= '0;
			col <= '0;
			is_write <= 1'b0;
			wdata <= '0;
		end else if (accept) begin
			row <= req_addr[2*ADDR_HALF-1:ADDR_HALF];
			col <= req_addr[ADDR_HALF-1:0];
			is_write <= req_write;
			wdata <= req_wdata;
		end
	end

	// Pin levels follow the state being entered
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			row_strobe_b <= 1'b1;
			col_strobe_b <= 1'b1;
			write_strobe_b <= 1'b1;
			mux_address_lines <= '0;
			byte_data_lines_out <= '0;
			byte_data_lines_oe <= 1'b0;
		end else begin
			row_strobe_b <= !(next_state inside {dram_host_pkg::st_wake_ras, dram_host_pkg::st_act,
				dram_host_pkg::st_setup, dram_host_pkg::st_col, dram_host_pkg::st_gap,
				dram_host_pkg::st_close, dram_host_pkg::st_cbr_ras, dram_host_pkg::st_hid_ras});
			col_strobe_b <= !(next_state inside {dram_host_pkg::st_col, dram_host_pkg::st_cbr_cas,
				dram_host_pkg::st_cbr_ras, dram_host_pkg::st_hid_pre, dram_host_pkg::st_hid_ras});
			// Write strobe low before the column falls: early write
			write_strobe_b <= !(next_state inside {dram_host_pkg::st_setup, dram_host_pkg::st_col} &&
				(accept ? req_write : is_write));
			// Data driven only for writes, never while a read may still drive
			byte_data_lines_oe <= next_state inside {dram_host_pkg::st_setup, dram_host_pkg::st_col} &&
				(accept ? req_write : is_write);
			byte_data_lines_out <= accept ? req_wdata : wdata;
			if (next_state == dram_host_pkg::st_wake_ras) begin
				mux_address_lines <= ADDR_HALF'(wake_count);
			end else if (next_state == dram_host_pkg::st_act) begin
				mux_address_lines <= req_addr[2*ADDR_HALF-1:ADDR_HALF];
			end else if (next_state == dram_host_pkg::st_setup) begin
				mux_address_lines <= accept ? req_addr[ADDR_HALF-1:0] : col;
			end
		end
	end

	// Two-flop synchroniser on the data pins
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dq_meta <= '0;
			dq_sync <= '0;
		end else begin
			dq_meta <= byte_data_lines_in;
			dq_sync <= dq_meta;
		end
	end

	// Read data sampled at the end of the column-low time, while still driven
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			rsp_valid <= (state == dram_host_pkg::st_col) && timer_done && !is_write;
			if ((state == dram_host_pkg::st_col) && timer_done && !is_write) begin
				rsp_rdata <= dq_sync;
			end
		end
	end

	// Checks of the pin timing, the refresh wait and the wake-up count, then covers
	a_ras_min_width: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(row_strobe_b) |-> (!row_strobe_b)[*8]) else $error("row strobe low too short");
	a_ras_max_width: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!row_strobe_b |-> 32'(ras_age) < dram_host_pkg::RAS_MAX_CYC)
		else $error("row strobe low too long");
	a_ras_precharge: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(row_strobe_b) |-> row_strobe_b[*6]) else $error("precharge too short");
	a_ras_spacing: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(row_strobe_b) |-> 32'($past(ras_age)) + 1 >= T_RC)
		else $error("row cycles too close");
	a_row_col_delay: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(col_strobe_b) && $past(state, 2) == dram_host_pkg::st_act |->
		ras_age >= AB'(dram_host_pkg::RCD_CYC) && ras_age <= AB'(dram_host_pkg::RCD_MAX_CYC))
		else $error("row to column delay out of range");
	a_page_gap_min: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(col_strobe_b) && !row_strobe_b |-> col_strobe_b[*3])
		else $error("column precharge too short");
	a_cbr_lead: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(row_strobe_b) && !col_strobe_b |-> !$past(col_strobe_b) && write_strobe_b)
		else $error("column did not lead row");
	a_early_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(col_strobe_b) && !write_strobe_b |-> !$past(write_strobe_b) && byte_data_lines_oe)
		else $error("write strobe not ahead of column");
	a_row_only_refresh: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state == dram_host_pkg::st_wake_ras |-> col_strobe_b && !mux_address_lines[ADDR_HALF-1])
		else $error("row-only refresh shape wrong");
	a_hidden_refresh: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state == dram_host_pkg::st_hid_pre |-> row_strobe_b && !col_strobe_b && write_strobe_b)
		else $error("hidden refresh shape wrong");
	a_refresh_served: assert property (@(posedge ref_clk) disable iff (!rst_b)
		refresh_due |-> 32'(refresh_age) < REF_AGE_LIMIT) else $error("refresh waited too long");
	a_wake_complete: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(init_done) |-> wake_count == 4'(dram_host_pkg::WAKE_CYCLES))
		else $error("ready before wake cycles");
	c_page_access: cover property (@(posedge ref_clk) disable iff (!rst_b)
		state == dram_host_pkg::st_gap && accept);
	c_hidden_refresh: cover property (@(posedge ref_clk) disable iff (!rst_b)
		state == dram_host_pkg::st_hid_ras);
	c_cbr_refresh: cover property (@(posedge ref_clk) disable iff (!rst_b)
		state == dram_host_pkg::st_cbr_ras);
	c_write: cover property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(col_strobe_b) && !write_strobe_b);
endmodule

// ===== design/dram_host_pkg.sv
// Constants for the host-side controller of a multiplexed-address dynamic memory module.
// Assumes a single 100 MHz clock; every time below is turned into cycles here.
// Behaviour
// - Row then column halves on shared address
// - Repeated column pulses within one open row
// - Refresh all 256 rows every 4 ms
// - Spread refresh cycles evenly over interval
// - Row-only refresh: row strobe, column high
// - Column strobe leads row strobe by 10 ns
// - Hidden refresh: column low, row strobe cycles
// - Early write: data captured at column fall
// - Row strobe low 80 to 10000 ns
// - Row strobe high at least 60 ns
// - Row fall to row fall 150 ns
// - Column falls 20 to 40 ns after row
// - Page column strobe high at least 25 ns
// - Wait 100 us, then 8 wake cycles
package dram_host_pkg;
	// Clock period
	localparam int CLK_PERIOD_NS = 10;
	// Printed times in nanoseconds
	localparam int T_RAS_MIN_NS = 80;
	localparam int T_RAS_MAX_NS = 10000;
	localparam int T_RP_NS = 60;
	localparam int T_RC_NS = 150;
	localparam int T_RCD_MIN_NS = 20;
	localparam int T_RCD_MAX_NS = 40;
	localparam int T_CP_NS = 25;
	localparam int T_OFF_NS = 25;
	localparam int T_CSR_NS = 10;
	localparam int T_CAC_NS = 40;
	localparam int T_RAC_NS = 80;
	localparam int T_CAS_NS = 40;
	localparam int T_INIT_NS = 100000;
	localparam int T_REF_NS = 4000000;
	// Refresh and wake-up counts
	localparam int REF_ROWS = 256;
	localparam int WAKE_CYCLES = 8;
	localparam int SYNC_STAGES = 2;
	// Least times round up, longest times round down
	localparam int RAS_MIN_CYC = (T_RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAS_MAX_CYC = T_RAS_MAX_NS / CLK_PERIOD_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RCD_CYC = (T_RCD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RCD_MAX_CYC = T_RCD_MAX_NS / CLK_PERIOD_NS;
	localparam int CP_CYC = (T_CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OFF_CYC = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CSR_CYC = (T_CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAC_CYC = (T_CAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAC_CYC = (T_RAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TCAS_CYC = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYC = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Refresh spacing is a longest time: round down
	localparam int REF_SPACING_CYC = T_REF_NS / (REF_ROWS * CLK_PERIOD_NS);
	// Column-low time of a read: worst access plus pin synchroniser plus one
	localparam int COL_READ_CYC = ((CAC_CYC > RAC_CYC - RCD_CYC) ? CAC_CYC :
		(RAC_CYC - RCD_CYC)) + SYNC_STAGES + 1;
	localparam int COL_WRITE_CYC = TCAS_CYC;
	// Cycles one more page access may take before the row must close
	localparam int PAGE_SLOT_CYC = COL_READ_CYC + CP_CYC + 2;
	// Timer and age counter widths
	localparam int TIMER_BITS = 14;
	localparam int AGE_BITS = 11;
	// Controller states
	typedef enum logic [3:0] {
		st_init, st_wake_ras, st_pre, st_idle, st_act, st_setup, st_col,
		st_gap, st_close, st_cbr_cas, st_cbr_ras, st_hid_pre, st_hid_ras
	} state_type;
endpackage

// ===== tb/async_dram_module_interface_tb_top.sv
// Self-checking bench for the host controller of the multiplexed-address memory.
// Assumes the device model stands on the memory pins; no checker is bound here.
`timescale 1ns/1ps
module async_dram_module_interface_tb_top;
	// Short power-up pause keeps the run brief
	localparam int INIT_W = 20;
	// Clock, reset and request side
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [17:0] req_addr = 18'h00000;
	logic [7:0] req_wdata = 8'h00;
	logic req_ready;
	logic rsp_valid;
	logic [7:0] rsp_rdata;
	logic init_done;
	// Memory pins and the resolved data wire
	logic row_strobe_b;
	logic col_strobe_b;
	logic write_strobe_b;
	logic [8:0] mux_address_lines;
	logic [7:0] dq_wire;
	logic [7:0] ctrl_dq;
	logic [7:0] dev_dq;
	logic ctrl_oe;
	logic dev_drive;
	// Counters, reference memory and queued operations
	int num_errors = 0;
	int check_count = 0;
	int seed = 32'h12A336FD;
	logic [7:0] ref_mem [int];
	logic [7:0] exp_q [$];
	int addr_list [$];
	bit op_wr [$];
	int op_addr [$];
	logic [7:0] op_data [$];
	// Pin timing history in cycles
	int cyc = 0;
	int wake_falls = 0;
	int t_rf = -10000;
	int t_rr = -10000;
	int t_cf = -10000;
	int t_cr = -10000;
	int t_ref = -1;
	logic row_d = 1'b1;
	logic col_d = 1'b1;

	always #5 ref_clk = ~ref_clk;
	// Controller wins the wire when it drives, else the device's view shows
	assign dq_wire = ctrl_oe ? ctrl_dq : dev_dq;

	dram_host_ctrl #(.ADDR_HALF(9), .DATA_BITS(8), .INIT_WAIT_CYC(INIT_W)) dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
		.row_strobe_b(row_strobe_b), .col_strobe_b(col_strobe_b),
		.write_strobe_b(write_strobe_b), .mux_address_lines(mux_address_lines),
		.byte_data_lines_in(dq_wire), .byte_data_lines_out(ctrl_dq),
		.byte_data_lines_oe(ctrl_oe));

	dram_device_model dev (
		.row_strobe_b(row_strobe_b), .col_strobe_b(col_strobe_b),
		.write_strobe_b(write_strobe_b), .mux_address_lines(mux_address_lines),
		.data_in(dq_wire), .data_out(dev_dq), .drive(dev_drive));

	// Single comparison point
	task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
		check_count++;
		if (seen !== expected) begin
			num_errors++;
			$display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, expected);
		end
	endtask

	// Verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Queue one operation; writes get random data
	task automatic add_op(input bit wr, input int a);
		op_wr.push_back(wr);
		op_addr.push_back(a & 32'h3FFFF);
		op_data.push_back(8'($random(seed)));
		if (wr) begin
			addr_list.push_back(a & 32'h3FFFF);
		end
	endtask

	// Offer queued operations back to back; valid drops after the last one
	task automatic run_batch();
		int n;
		int a;
		while (op_addr.size() > 0) begin
			a = op_addr.pop_front();
			req_valid = 1'b1;
			req_write = op_wr.pop_front();
			req_addr = a[17:0];
			req_wdata = op_data.pop_front();
			if (req_write) begin
				ref_mem[a] = req_wdata;
			end else begin
				exp_q.push_back(ref_mem[a]);
			end
			n = 0;
			#1;
			// Taken at the next rising edge once ready shows
			while (req_ready !== 1'b1 && n < 3000) begin
				@(negedge ref_clk);
				#1;
				n++;
			end
			check(n < 3000, 1, "request never taken");
			@(negedge ref_clk);
		end
		req_valid = 1'b0;
	endtask

	// Bounded wait for the wake-up sequence to finish
	task automatic wait_init();
		int n;
		n = 0;
		while (init_done !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		check(wake_falls, 8, "wake row cycles");
		// Pause, seven row cycle spacings, then the last row low and precharge
		check(n >= INIT_W + 7 * 15 + 8 + 6, 1, "power-up pause");
	endtask

	// Strobe timing measured at the pins in whole cycles
	always @(negedge ref_clk) begin
		cyc++;
		if (rst_b && row_d && !row_strobe_b) begin
			wake_falls += !init_done;
			check(cyc - t_rr >= 6, 1, "row high time");
			check(cyc - t_rf >= 15, 1, "row cycle time");
			if (!col_strobe_b) begin
				check(cyc - t_cf >= 1, 1, "column lead");
				check(write_strobe_b, 1, "write strobe in refresh");
				if (t_ref >= 0) begin
					check(cyc - t_ref <= dram_host_pkg::REF_SPACING_CYC + 1000, 1, "refresh gap");
				end
				t_ref = cyc;
			end
			t_rf = cyc;
		end
		if (rst_b && !row_d && row_strobe_b) begin
			check(cyc - t_rf >= 8 && cyc - t_rf <= 1000, 1, "row low width");
			if (!init_done) begin
				check(t_cf < t_rf, 1, "column moved in wake");
			end
			t_rr = cyc;
		end
		if (rst_b && col_d && !col_strobe_b && !row_strobe_b) begin
			// First column of a row, or a page column after a high gap
			if (t_cr < t_rf) begin
				check(cyc - t_rf >= 2 && cyc - t_rf <= 4, 1, "row to column");
			end else begin
				check(cyc - t_cr >= 3, 1, "page column high");
			end
		end
		if (col_d && !col_strobe_b) begin
			t_cf = cyc;
		end
		if (!col_d && col_strobe_b) begin
			t_cr = cyc;
		end
		row_d = row_strobe_b;
		col_d = col_strobe_b;
		// Answers in request order
		if (rst_b && rsp_valid === 1'b1) begin
			check(exp_q.size() > 0, 1, "unexpected answer");
			if (exp_q.size() > 0) begin
				check(rsp_rdata, exp_q.pop_front(), "read data");
			end
		end
	end

	// Device release lands on falling edges, so contention is judged at rising ones
	always @(posedge ref_clk) begin
		if (rst_b && ctrl_oe === 1'b1) begin
			check(dev_drive, 0, "data contention");
		end
	end

	// Hang guard, well beyond the expected length
	initial begin
		#(60000 * 10);
		check(0, 1, "watchdog");
		end_sim();
	end

	initial begin
		int a;
		repeat (20) @(negedge ref_clk);
		rst_b = 1'b1;
		wait_init();
		$display("test wake done");
		// Boundaries, scattered writes, then page writes in one row
		add_op(1, 0);
		add_op(1, 32'h3FFFF);
		for (int i = 0; i < 10; i++) begin
			add_op(1, $random(seed));
		end
		for (int i = 0; i < 6; i++) begin
			add_op(1, 32'h2AA00 + i * 37);
		end
		run_batch();
		$display("test writes done");
		// Read back in order; the same-row run goes as page reads
		foreach (addr_list[i]) begin
			add_op(0, addr_list[i]);
		end
		run_batch();
		$display("test readback done");
		// Idle long enough for column-first refresh slots
		repeat (4000) @(negedge ref_clk);
		check(t_ref >= 0, 1, "no refresh seen");
		$display("test idle refresh done");
		// Random mix with gaps so refresh slots meet reads in flight
		for (int k = 0; k < 40; k++) begin
			a = $random(seed);
			if ($random(seed) & 1) begin
				add_op(1, (k % 2) ? (addr_list[$] & 32'h3FE00) | (a & 32'h1FF) : a);
			end else begin
				add_op(0, addr_list[$unsigned(a) % addr_list.size()]);
			end
			if (k % 4 == 3) begin
				run_batch();
				repeat ($unsigned($random(seed)) % 40) @(negedge ref_clk);
			end
		end
		$display("test random mix done");
		// Reset lands in the middle of a read
		req_addr = addr_list[0][17:0];
		req_write = 1'b0;
		req_valid = 1'b1;
		repeat (4) @(negedge ref_clk);
		rst_b = 1'b0;
		req_valid = 1'b0;
		#1;
		check({row_strobe_b, col_strobe_b, ctrl_oe, init_done}, 4'hC, "pins in reset");
		exp_q.delete();
		wake_falls = 0;
		t_ref = -1;
		repeat (20) @(negedge ref_clk);
		rst_b = 1'b1;
		wait_init();
		foreach (addr_list[i]) begin
			add_op(0, addr_list[i]);
		end
		run_batch();
		repeat (30) @(negedge ref_clk);
		check(exp_q.size(), 0, "answers missing");
		// Cells hold what was written at the right row and column
		foreach (ref_mem[k]) begin
			check(dev.mem.exists(k) ? dev.mem[k] : 8'hXX, ref_mem[k], "cell content");
		end
		$display("test reset and contents done");
		end_sim();
	end
endmodule

// ===== tb/dram_device_model.sv
// Behavioural model of the byte-wide multiplexed-address dynamic memory.
// Assumes the bench resolves the shared data wire and feeds it back in.
`timescale 1ns/1ps
module dram_device_model #(
	parameter int ROW_ACCESS_NS = 80,
	parameter int COL_ACCESS_NS = 40,
	parameter int RELEASE_NS = 25
) (
	// Strobes, active low
	input wire logic row_strobe_b,
	input wire logic col_strobe_b,
	input wire logic write_strobe_b,
	// Address half and resolved data wire
	input wire logic [8:0] mux_address_lines,
	input wire logic [7:0] data_in,
	// Device side of the data wire
	output logic [7:0] data_out,
	output logic drive
);
	// Cell array, only written places exist
	logic [7:0] mem [int];
	// Latched row, open flag and own refresh counter
	logic [8:0] row = 9'h000;
	logic open_row = 1'b0;
	logic [7:0] refresh_row = 8'h00;
	// Last driven byte; a released wire shows its inverse, never a kind value
	logic [7:0] last = 8'h00;
	int t_row = 0;
	int addr;
	int wait_ns;
	int tag = 0;
	int my_tag;

	initial begin
		drive = 1'b0;
		data_out = 8'hFF;
	end

	// Row fall: latch the row, or refresh from the own counter when column is low
	always @(negedge row_strobe_b) begin
		t_row = int'($time);
		// Address moves on the strobe's own clock edge; look a moment later
		#1;
		if (col_strobe_b === 1'b0) begin
			// Output left alone, so a hidden refresh keeps its data
			refresh_row = refresh_row + 8'h01;
			open_row = 1'b0;
		end else begin
			row = mux_address_lines;
			open_row = 1'b1;
		end
	end

	// Row rise ends the cycle; any later access needs a fresh row
	always @(posedge row_strobe_b) begin
		open_row = 1'b0;
	end

	// Column fall: early write stores, read drives junk until the access time
	always @(negedge col_strobe_b) begin
		if (row_strobe_b === 1'b0 && open_row) begin
			addr = int'({row, mux_address_lines});
			if (write_strobe_b === 1'b0) begin
				mem[addr] = data_in;
				drive = 1'b0;
			end else begin
				tag = tag + 1;
				my_tag = tag;
				drive = 1'b1;
				data_out = ~last;
				wait_ns = ROW_ACCESS_NS - (int'($time) - t_row);
				// Late column: access runs from the column alone
				if (wait_ns < COL_ACCESS_NS) begin
					wait_ns = COL_ACCESS_NS;
				end
				#(wait_ns);
				if (my_tag == tag && col_strobe_b === 1'b0) begin
					data_out = mem.exists(addr) ? mem[addr] : 8'h00;
					last = data_out;
				end
			end
		end
	end

	// Column rise: hold data for the full release time, then let go
	always @(posedge col_strobe_b) begin
		tag = tag + 1;
		#(RELEASE_NS);
		if (col_strobe_b === 1'b1) begin
			drive = 1'b0;
			data_out = ~last;
		end
	end
endmodule
